// [rtl/spi_err_core.sv]
// Error flags, interrupt request and low-power control of the SPI port
// Assumes pins arrive asynchronously and the CPU strobes are on ref_clk
`include "spi_err_map.svh"
module spi_err_core import spi_err_pkg::*; (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Link pins
   input wire logic sck_pin,
   input wire logic ss_n_pin,
   input wire logic data_pin,
   // Control writes
   input wire logic ctrl_wr,
   input wire logic wr_irq_enable_bit,
   input wire logic wr_port_enable_bit,
   input wire logic wr_master_select_bit,
   input wire logic wr_sample_rise,
   input wire logic csr_wr,
   input wire logic wr_soft_select_mode,
   input wire logic wr_soft_select_level,
   // Status and data accesses
   input wire logic csr_rd,
   input wire logic data_rd,
   input wire logic data_wr,
   input wire byte_t data_wdata,
   // Power modes
   input wire logic halt_req,
   // Control state
   output logic irq_enable_bit,
   output logic port_enable_bit,
   output logic master_select_bit,
   output logic soft_select_mode,
   output logic soft_select_level,
   // Status
   output logic transfer_done_flag,
   output logic write_collision_flag,
   output logic overrun_flag,
   output logic mode_fault_flag,
   output byte_t data_reg,
   output byte_t tx_byte,
   // Interrupt and wake
   output logic irq,
   output logic wait_wake,
   output logic halt_wake,
   output logic halted
);
   // ------------------------------------------------------------
   // Pin synchronisation
   // ------------------------------------------------------------
   logic ss_lvl;
   logic sck_lvl;
   logic sck_rise;
   logic sck_fall;
   logic data_lvl;
   sync_edge u_ss (
      .ref_clk(ref_clk), .rst_n(rst_n), .async_in(ss_n_pin),
      .level(ss_lvl), .rise(), .fall()
   );
   sync_edge u_sck (
      .ref_clk(ref_clk), .rst_n(rst_n), .async_in(sck_pin),
      .level(sck_lvl), .rise(sck_rise), .fall(sck_fall)
   );
   sync_edge u_dat (
      .ref_clk(ref_clk), .rst_n(rst_n), .async_in(data_pin),
      .level(data_lvl), .rise(), .fall()
   );

   // ------------------------------------------------------------
   // Link settling after reset
   // ------------------------------------------------------------
   // Edges are ignored until the synchronisers hold real pin levels
   logic [`SETTLE_W-1:0] settle_q;
   wire link_ready = settle_q[`SETTLE_W-1];
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_q <= '0;
      end else begin
         settle_q <= {settle_q[`SETTLE_W-2:0], 1'b1};
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic irqen_q, irqen_d;
   logic spe_q, spe_d;
   logic master_select_bit_q, master_select_bit_d;
   logic rise_q, rise_d;
   logic ssm_q, ssm_d;
   logic ssi_q, ssi_d;
   logic done_q, done_d;
   logic write_collision_flag_q, write_collision_flag_d;
   logic ovr_q, ovr_d;
   logic mode_fault_flag_q, mode_fault_flag_d;
   logic done_armed_q, done_armed_d;
   logic write_collision_flag_armed_q, write_collision_flag_armed_d;
   logic mode_fault_flag_armed_q, mode_fault_flag_armed_d;
   byte_t rbuf_q, rbuf_d;
   byte_t tx_q, tx_d;
   power_t pwr_q, pwr_d;
   logic halt_ok_q, halt_ok_d;
   logic irq_q, wait_q, hwake_q, halted_q;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire frozen = (pwr_q == halt_st);
   wire ss_int = ssm_q ? ssi_q : ss_lvl;
   wire fault_ev = !frozen & spe_q & master_select_bit_q & !ss_int;
   wire slave_act = !frozen & spe_q & !master_select_bit_q & !ss_int;
   wire sample = link_ready & (rise_q ? sck_rise : sck_fall);
   byte_t shifted;
   logic busy;
   logic byte_done;
   rx_shifter u_shift (
      .ref_clk(ref_clk), .rst_n(rst_n), .active(slave_act),
      .sample(sample), .data_in(data_lvl),
      .shift_out(shifted), .busy(busy), .done(byte_done)
   );
   wire ovr_ev = byte_done & done_q;
   wire write_collision_flag_ev = !frozen & data_wr & busy;
   wire data_acc = data_rd | data_wr;
   wire mode_fault_flag_clr = mode_fault_flag_armed_q & ctrl_wr;
   wire in_clear = mode_fault_flag_armed_q | csr_rd;
   wire set_block = mode_fault_flag_q & !in_clear;
   wire byte_done_halt = sample & !master_select_bit_q & spe_q & !ss_int;
   wire halt_wake_ev = frozen & halt_ok_q & byte_done_halt;
   wire halt_slave = !ssm_q | !ssi_q;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      irqen_d = irqen_q;
      spe_d = spe_q;
      master_select_bit_d = master_select_bit_q;
      rise_d = rise_q;
      ssm_d = ssm_q;
      ssi_d = ssi_q;
      if (!frozen && ctrl_wr) begin
         irqen_d = wr_irq_enable_bit;
         rise_d = wr_sample_rise;
         spe_d = wr_port_enable_bit & !set_block;
         master_select_bit_d = wr_master_select_bit & !set_block;
      end
      if (!frozen && csr_wr) begin
         ssm_d = wr_soft_select_mode;
         ssi_d = wr_soft_select_level;
      end
      if (fault_ev) begin
         spe_d = 1'b0;
         master_select_bit_d = 1'b0;
      end
   end

   always_comb begin
      done_d = done_q;
      write_collision_flag_d = write_collision_flag_q;
      ovr_d = ovr_q;
      mode_fault_flag_d = mode_fault_flag_q;
      done_armed_d = done_armed_q;
      write_collision_flag_armed_d = write_collision_flag_armed_q;
      mode_fault_flag_armed_d = mode_fault_flag_armed_q;
      rbuf_d = rbuf_q;
      tx_d = tx_q;
      if (!frozen) begin
         if (csr_rd) begin
            done_armed_d = done_q;
            write_collision_flag_armed_d = write_collision_flag_q;
            mode_fault_flag_armed_d = mode_fault_flag_q;
            ovr_d = 1'b0;
         end
         if (csr_wr) begin
            done_armed_d = done_q;
         end
         if (data_acc && done_armed_q) begin
            done_d = 1'b0;
            done_armed_d = 1'b0;
         end
         if (data_acc && write_collision_flag_armed_q) begin
            write_collision_flag_d = 1'b0;
            write_collision_flag_armed_d = 1'b0;
         end
         if (mode_fault_flag_clr) begin
            mode_fault_flag_d = 1'b0;
            mode_fault_flag_armed_d = 1'b0;
         end
         if (data_wr && !busy && !done_q) begin
            tx_d = data_wdata;
         end
      end
      if (byte_done && !done_q) begin
         rbuf_d = shifted;
      end
      if (byte_done) begin
         done_d = 1'b1;
      end
      if (ovr_ev) begin
         ovr_d = 1'b1;
      end
      if (write_collision_flag_ev) begin
         write_collision_flag_d = 1'b1;
      end
      if (fault_ev) begin
         mode_fault_flag_d = 1'b1;
      end
      if (halt_wake_ev) begin
         done_d = 1'b1;
         if (done_q) begin
            ovr_d = 1'b1;
         end else begin
            rbuf_d = shifted;
         end
      end
   end

   // ------------------------------------------------------------
   // Power state
   // ------------------------------------------------------------
   always_comb begin
      pwr_d = pwr_q;
      halt_ok_d = halt_ok_q;
      unique case (pwr_q)
         run_st: begin
            if (halt_req) begin
               pwr_d = halt_st;
               halt_ok_d = spe_q & !master_select_bit_q & !ss_int & halt_slave;
            end
         end
         halt_st: begin
            if (halt_wake_ev || !halt_req) begin
               pwr_d = master_select_bit_q ? run_st : recover_st;
            end
         end
         recover_st: begin
            if (master_select_bit_q || byte_done || !spe_q) begin
               pwr_d = run_st;
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // Flip-flops
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irqen_q <= 1'b0;
         spe_q <= 1'b0;
         master_select_bit_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         irqen_q <= irqen_d;
         spe_q <= spe_d;
         master_select_bit_q <= master_select_bit_d;
         rise_q <= rise_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ssm_q <= 1'b0;
         ssi_q <= 1'b0;
      end else begin
         ssm_q <= ssm_d;
         ssi_q <= ssi_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_q <= 1'b0;
         write_collision_flag_q <= 1'b0;
         ovr_q <= 1'b0;
         mode_fault_flag_q <= 1'b0;
      end else begin
         done_q <= done_d;
         write_collision_flag_q <= write_collision_flag_d;
         ovr_q <= ovr_d;
         mode_fault_flag_q <= mode_fault_flag_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_armed_q <= 1'b0;
         write_collision_flag_armed_q <= 1'b0;
         mode_fault_flag_armed_q <= 1'b0;
      end else begin
         done_armed_q <= done_armed_d;
         write_collision_flag_armed_q <= write_collision_flag_armed_d;
         mode_fault_flag_armed_q <= mode_fault_flag_armed_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rbuf_q <= `DATA_RST;
         tx_q <= `DATA_RST;
      end else begin
         rbuf_q <= rbuf_d;
         tx_q <= tx_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwr_q <= run_st;
         halt_ok_q <= 1'b0;
         halted_q <= 1'b0;
      end else begin
         pwr_q <= pwr_d;
         halt_ok_q <= halt_ok_d;
         halted_q <= (pwr_d == halt_st);
      end
   end

   // ------------------------------------------------------------
   // Interrupt and wake
   // ------------------------------------------------------------
   wire irq_src = done_d | ovr_d | mode_fault_flag_d;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
         wait_q <= 1'b0;
         hwake_q <= 1'b0;
      end else begin
         irq_q <= irqen_d & irq_src;
         wait_q <= irqen_d & irq_src;
         hwake_q <= halt_wake_ev & irqen_q;
      end
   end

   assign irq_enable_bit = irqen_q;
   assign port_enable_bit = spe_q;
   assign master_select_bit = master_select_bit_q;
   assign soft_select_mode = ssm_q;
   assign soft_select_level = ssi_q;
   assign transfer_done_flag = done_q;
   assign write_collision_flag = write_collision_flag_q;
   assign overrun_flag = ovr_q;
   assign mode_fault_flag = mode_fault_flag_q;
   assign data_reg = rbuf_q;
   assign tx_byte = tx_q;
   assign irq = irq_q;
   assign wait_wake = wait_q;
   assign halt_wake = hwake_q;
   assign halted = halted_q;
endmodule : spi_err_core

// [rtl/spi_err_map.svh]
// Constants for the SPI error, interrupt and low-power block
// Assumes inclusion by the package, the core and the shift counter
// Overview of operation
// - Master with select low sets fault flag
// - Fault raises interrupt when enabled
// - Fault clears port enable bit
// - Fault clears master select bit
// - Fault flag clears: status read, control write
// - Fault blocks setting enable and master bits
// - Enable and master restorable in clearing sequence
// - Byte done with flag set sets overrun
// - Buffer keeps first byte after overrun
// - Status read clears overrun flag
// - Data write during transfer is ignored
// - Ignored write sets collision flag
// - Collision flag never raises interrupt
// - Received byte buffered, read synchronously
// - Wait mode runs normally, events wake
// - Halt freezes registers until wake-up
// - Slave transfer done wakes from Halt
// - Halt wake needs select low at entry
// - Slave stays in recovery after Halt until a byte completes, the port is disabled or the master bit is set
// - Events share vector; only done exits Halt
// - Done flag clears: status access, data access
// - Soft select mode uses soft level
`ifndef SPI_ERR_MAP_SVH
`define SPI_ERR_MAP_SVH
`define BYTE_W 8
`define BIT_CNT_W 3
`define BIT_LAST 3'h7
`define SETTLE_W 3
`define DATA_RST 8'h00
`endif

// [rtl/spi_err_pkg.sv]
// Types shared by the SPI error block
// Assumes the constants header is on the include path
`include "spi_err_map.svh"
package spi_err_pkg;
   typedef logic [`BYTE_W-1:0] byte_t;
   typedef enum logic [1:0] {run_st, halt_st, recover_st} power_t;
endpackage : spi_err_pkg

// [rtl/sync_edge.sv]
// Two-flop synchroniser with edge detection on the synchronised copy
// Assumes an asynchronous input and the block clock
module sync_edge (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Signal
   input wire logic async_in,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_q;
   logic sync_q;
   logic prev_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
         prev_q <= 1'b1;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end
   assign level = sync_q;
   assign rise = sync_q & ~prev_q;
   assign fall = ~sync_q & prev_q;
endmodule : sync_edge

// [rtl/rx_shifter.sv]
// Serial shift counter for one byte on the sampled link clock
// Assumes sample strobes from the synchronised link clock
`include "spi_err_map.svh"
module rx_shifter import spi_err_pkg::*; (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Control
   input wire logic active,
   input wire logic sample,
   input wire logic data_in,
   // Result
   output byte_t shift_out,
   output logic busy,
   output logic done
);
   logic [`BIT_CNT_W-1:0] cnt_q;
   byte_t sh_q;
   logic busy_q;
   wire last = sample & (cnt_q == `BIT_LAST);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         sh_q <= `DATA_RST;
         busy_q <= 1'b0;
      end else if (!active) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
      end else if (sample) begin
         cnt_q <= cnt_q + 3'h1;
         sh_q <= {sh_q[`BYTE_W-2:0], data_in};
         busy_q <= ~last;
      end
   end
   assign shift_out = {sh_q[`BYTE_W-2:0], data_in};
   assign busy = busy_q | (active & sample);
   assign done = active & last;
endmodule : rx_shifter

// [bench/spi_err_assertions.sv]
// Checker for the SPI error, interrupt and low-power block
// Assumes binding onto spi_err_core, all on ref_clk
module spi_err_assertions (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Accesses
   input wire logic ctrl_wr,
   input wire logic csr_rd,
   input wire logic data_rd,
   input wire logic data_wr,
   // Watched outputs
   input wire logic irq_enable_bit,
   input wire logic port_enable_bit,
   input wire logic master_select_bit,
   input wire logic transfer_done_flag,
   input wire logic write_collision_flag,
   input wire logic overrun_flag,
   input wire logic mode_fault_flag,
   input wire logic irq,
   input wire logic wait_wake,
   input wire logic halt_wake
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // Fault clearing armed by a status read
   // ----------------------------------------
   logic armed_q;
   logic armed_d;
   assign armed_d = mode_fault_flag && (armed_q || csr_rd);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) armed_q <= 1'b0;
      else armed_q <= armed_d;
   end
   irq_merge_a: assert property (irq == (irq_enable_bit &&
      (transfer_done_flag || overrun_flag || mode_fault_flag))) else $error("irq wrong");
   fault_bits_a: assert property ($rose(mode_fault_flag) |->
      !port_enable_bit && !master_select_bit) else $error("fault kept bits");
   fault_clear_a: assert property ($fell(mode_fault_flag) |-> $past(ctrl_wr))
      else $error("fault cleared early");
   fault_block_a: assert property ($rose(port_enable_bit) && $past(mode_fault_flag) |->
      $past(armed_q || csr_rd)) else $error("enable set in fault");
   ovr_cause_a: assert property ($rose(overrun_flag) |-> $past(transfer_done_flag))
      else $error("overrun without done");
   ovr_clear_a: assert property ($fell(overrun_flag) |-> $past(csr_rd))
      else $error("overrun cleared wrongly");
   write_collision_flag_cause_a: assert property ($rose(write_collision_flag) |-> $past(data_wr))
      else $error("collision without write");
   done_clear_a: assert property ($fell(transfer_done_flag) |-> $past(data_rd || data_wr))
      else $error("done cleared wrongly");
   halt_wake_a: assert property (halt_wake |-> ##[0:1] transfer_done_flag)
      else $error("wake without done");
   wait_wake_a: assert property (wait_wake |-> irq)
      else $error("wait wake without irq");
   cover property ($rose(overrun_flag));
   cover property ($rose(write_collision_flag));
   cover property ($rose(mode_fault_flag));
   cover property (halt_wake);
endmodule : spi_err_assertions

bind spi_err_core spi_err_assertions spi_err_assertions_i (.ref_clk, .rst_n, .ctrl_wr,
   .csr_rd, .data_rd, .data_wr, .irq_enable_bit, .port_enable_bit, .master_select_bit,
   .transfer_done_flag, .write_collision_flag, .overrun_flag, .mode_fault_flag, .irq,
   .wait_wake, .halt_wake);

// [bench/spi_link_master.sv]
// Far-side link master: select, clock and serial data
// Assumes the block samples on the rising edge, or the falling one for send_late
module spi_link_master (
   // Link pins
   output logic sck,
   output logic ss_n,
   output logic mosi
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sck = 1'b0;
      ss_n = 1'b1;
      mosi = 1'b1;
   end
   // Select level, high while a fault clears, low across slave Halt
   task automatic sel(input logic lvl);
      ss_n = lvl;
   endtask : sel
   // One byte MSB first; clock idles low between bytes
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         mosi = b[i];
         #100 sck = 1'b1;
         #100 sck = 1'b0;
      end
      mosi = ~b[0];
   endtask : send
   // One byte MSB first, data moved on the rising edge for falling-edge capture
   task automatic send_late(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         mosi = b[i];
         sck = 1'b1;
         #100 sck = 1'b0;
         #100;
      end
      mosi = ~b[0];
   endtask : send_late
endmodule : spi_link_master

// [bench/tb_top.sv]
// Self-checking bench for the SPI error block
// Assumes the link master model and the checker are compiled first
module tb_top import spi_err_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst_n;
   logic ctrl_wr, csr_wr, csr_rd, data_rd, data_wr;
   logic wr_irq_enable_bit, wr_port_enable_bit, wr_master_select_bit;
   logic wr_sample_rise, wr_soft_select_mode, wr_soft_select_level;
   logic halt_req;
   logic woke = 1'b0;
   byte_t data_wdata;
   byte_t data_reg, tx_byte;
   wire logic sck, ss_n, mosi;
   logic irq_enable_bit, port_enable_bit, master_select_bit, soft_select_mode;
   logic soft_select_level, transfer_done_flag, write_collision_flag, overrun_flag;
   logic mode_fault_flag, irq, wait_wake, halt_wake, halted;
   int miscompares = 0;
   int checked = 0;
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (halt_wake === 1'b1) woke <= 1'b1;
   spi_link_master spi_link_master_i (.sck, .ss_n, .mosi);
   spi_err_core spi_err_core_i (.ref_clk, .rst_n, .sck_pin(sck), .ss_n_pin(ss_n),
      .data_pin(mosi), .ctrl_wr, .wr_irq_enable_bit, .wr_port_enable_bit,
      .wr_master_select_bit, .wr_sample_rise, .csr_wr, .wr_soft_select_mode,
      .wr_soft_select_level, .csr_rd, .data_rd, .data_wr, .data_wdata, .halt_req,
      .irq_enable_bit, .port_enable_bit, .master_select_bit, .soft_select_mode,
      .soft_select_level, .transfer_done_flag, .write_collision_flag, .overrun_flag,
      .mode_fault_flag, .data_reg, .tx_byte, .irq, .wait_wake, .halt_wake, .halted);
   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic tally_and_finish;
      if (miscompares == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask : chk
   // Strobe order: ctrl_wr, csr_wr, csr_rd, data_rd, data_wr
   task automatic acc(input logic [4:0] s);
      @(negedge ref_clk);
      {ctrl_wr, csr_wr, csr_rd, data_rd, data_wr} = s;
      @(negedge ref_clk);
      {ctrl_wr, csr_wr, csr_rd, data_rd, data_wr} = 5'h00;
      repeat (2) @(negedge ref_clk);
   endtask : acc
   task automatic ctl(input logic ie, input logic pe, input logic ms);
      @(negedge ref_clk);
      {wr_irq_enable_bit, wr_port_enable_bit, wr_master_select_bit} = {ie, pe, ms};
      acc(5'h10);
   endtask : ctl
   task automatic settle;
      repeat (6) @(negedge ref_clk);
   endtask : settle
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      {ctrl_wr, csr_wr, csr_rd, data_rd, data_wr} = 5'h00;
      {wr_irq_enable_bit, wr_port_enable_bit, wr_master_select_bit} = 3'h0;
      {wr_sample_rise, wr_soft_select_mode, wr_soft_select_level} = 3'h4;
      halt_req = 1'b0;
      data_wdata = 8'h00;
      repeat (3) @(negedge ref_clk);
      rst_n = 1'b1;
      spi_link_master_i.sel(1'b0);
      ctl(1'b1, 1'b1, 1'b0);
      spi_link_master_i.send(8'hA5);
      settle;
      chk(data_reg, 8'hA5, "rx byte");
      chk(wait_wake, 8'h01, "no wait wake");
      spi_link_master_i.send(8'h3C);
      settle;
      chk(overrun_flag, 8'h01, "no overrun");
      chk(irq, 8'h01, "no irq");
      chk(data_reg, 8'hA5, "later byte kept");
      acc(5'h04);
      chk(overrun_flag, 8'h00, "overrun stuck");
      acc(5'h02);
      chk(transfer_done_flag, 8'h00, "done stuck");
      fork
         spi_link_master_i.send(8'hC3);
         begin
            #400 data_wdata = 8'h55;
            acc(5'h01);
            chk(write_collision_flag, 8'h01, "no collision");
            chk(irq, 8'h00, "collision irq");
         end
      join
      settle;
      chk(data_reg, 8'hC3, "transfer spoiled");
      chk(tx_byte, 8'h00, "write taken");
      acc(5'h04);
      acc(5'h02);
      chk(write_collision_flag, 8'h00, "collision stuck");
      data_wdata = 8'h3C;
      acc(5'h01);
      chk(tx_byte, 8'h3C, "idle write lost");
      spi_link_master_i.sel(1'b1);
      settle;
      ctl(1'b1, 1'b1, 1'b1);
      spi_link_master_i.sel(1'b0);
      settle;
      chk(mode_fault_flag, 8'h01, "no fault");
      chk(irq, 8'h01, "fault irq");
      chk(port_enable_bit, 8'h00, "enable kept");
      chk(master_select_bit, 8'h00, "master kept");
      spi_link_master_i.sel(1'b1);
      settle;
      ctl(1'b1, 1'b1, 1'b1);
      chk(port_enable_bit, 8'h00, "enable set in fault");
      chk(mode_fault_flag, 8'h01, "fault cleared early");
      acc(5'h04);
      ctl(1'b1, 1'b1, 1'b1);
      chk(mode_fault_flag, 8'h00, "fault stuck");
      chk(master_select_bit, 8'h01, "master not restored");
      ctl(1'b1, 1'b1, 1'b0);
      {wr_soft_select_mode, wr_soft_select_level} = 2'h3;
      acc(5'h08);
      spi_link_master_i.sel(1'b0);
      spi_link_master_i.send(8'h69);
      settle;
      chk(transfer_done_flag, 8'h00, "soft deselect rx");
      wr_soft_select_level = 1'b0;
      spi_link_master_i.sel(1'b1);
      acc(5'h08);
      wr_sample_rise = 1'b0;
      ctl(1'b1, 1'b1, 1'b0);
      spi_link_master_i.send_late(8'h96);
      settle;
      chk(data_reg, 8'h96, "soft select rx");
      acc(5'h04);
      acc(5'h02);
      wr_soft_select_mode = 1'b0;
      acc(5'h08);
      wr_sample_rise = 1'b1;
      ctl(1'b1, 1'b1, 1'b0);
      spi_link_master_i.sel(1'b0);
      settle;
      halt_req = 1'b1;
      settle;
      chk(halted, 8'h01, "not halted");
      ctl(1'b0, 1'b1, 1'b0);
      chk(irq_enable_bit, 8'h01, "write in halt");
      spi_link_master_i.send(8'h5A);
      settle;
      chk(woke, 8'h01, "no halt wake");
      halt_req = 1'b0;
      acc(5'h04);
      acc(5'h02);
      spi_link_master_i.send(8'h0F);
      settle;
      chk(transfer_done_flag, 8'h01, "no recovery byte");
      tally_and_finish;
   end
   initial begin
      #200000;
      miscompares++;
      tally_and_finish;
   end
endmodule : tb_top
